//--- hw/lbc_pkg.sv
// Package of constants for the laser bias configuration register bank.
// Assumes an 8-bit register port fed by the serial host front end on sys_clk.
package lbc_pkg;
   // Register offsets on the 8-bit register port.
   localparam logic [7:0] LBC_ADDR_RANGE   = 8'h04;
   localparam logic [7:0] LBC_ADDR_GAINOFS = 8'h05;
   localparam logic [7:0] LBC_ADDR_MONSEL  = 8'h06;
   localparam logic [7:0] LBC_ADDR_DRIVE   = 8'h20;
   localparam logic [7:0] LBC_ADDR_DAC_HI  = 8'h21;
   // Field positions.
   localparam int LBC_RANGE_BIT  = 0;
   localparam int LBC_GAIN_BIT   = 3;
   localparam int LBC_OFS_LSB    = 0;
   localparam int LBC_OFS_W      = 3;
   localparam int LBC_MON_LSB    = 0;
   localparam int LBC_MON_W      = 2;
   // Writable bit masks; all other bits are reserved.
   localparam logic [7:0] LBC_MASK_RANGE   = 8'h01;
   localparam logic [7:0] LBC_MASK_GAINOFS = 8'h0F;
   localparam logic [7:0] LBC_MASK_MONSEL  = 8'h03;
   // Reset values.
   localparam logic [7:0] LBC_RST_RANGE   = 8'h00;
   localparam logic [7:0] LBC_RST_GAINOFS = 8'h00;
   localparam logic [7:0] LBC_RST_MONSEL  = 8'h03;
   localparam logic [7:0] LBC_RST_DRIVE   = 8'h00;
   // Drive current result width, in 0.25 mA units (max 958).
   localparam int LBC_CUR_W = 10;
   // Offset step of 16 mA expressed in 0.25 mA units at unity gain.
   localparam logic [LBC_CUR_W-1:0] LBC_OFS_STEP_Q = 10'h040;
endpackage : lbc_pkg

//--- hw/lbc_drive_calc.sv
// Combinational drive current calculation for the laser drive converter.
// Assumes code, gain and offset are the next-state values of registers in the same clock domain.
`timescale 1ns/10ps
module lbc_drive_calc
   import lbc_pkg::*;
(
   input  wire logic [7:0]           drive_code,      // Converter code.
   input  wire logic                 gain_half,       // Set for half gain.
   input  wire logic [2:0]           offset_sel,      // Offset step count.
   output logic      [LBC_CUR_W-1:0] current_q        // Drive current, 0.25 mA units.
);
   logic [LBC_CUR_W-1:0] unity_q;                      // Current at unity gain.

   // Unity current is 16 mA per offset step plus code times 0.5 mA.
   always_comb
   begin
      unity_q = LBC_CUR_W'(offset_sel) * LBC_OFS_STEP_Q
              + LBC_CUR_W'({drive_code, 1'b0});
      // Half gain halves the whole sum, giving the 119.75 mA span.
      if (gain_half)
      begin
         current_q = unity_q >> 1;
      end
      else
      begin
         current_q = unity_q;
      end
   end
endmodule : lbc_drive_calc

//--- hw/lbc_regs.sv
// Configuration register bank for the laser bias controller.
// Assumes a serial host front end on sys_clk presenting one-cycle strobes.
`timescale 1ns/10ps
module lbc_regs
   import lbc_pkg::*;
(
   input  wire logic                 sys_clk,             // System clock, 50 MHz.
   input  wire logic                 reset_n,             // Asynchronous reset, active low.
   input  wire logic                 reg_wr_en,           // Write strobe, one cycle.
   input  wire logic                 reg_rd_en,           // Read strobe, one cycle.
   input  wire logic [7:0]           reg_addr,            // Register offset.
   input  wire logic [7:0]           reg_wdata,           // Write data.
   output logic      [7:0]           reg_rdata,           // Read data.
   output logic                      reg_rd_valid,        // Read data valid pulse.
   output logic                      monitor_photodiode_low_range, // Set for 1:8 range.
   output logic                      laser_diode_gain_half,        // Set for half gain.
   output logic      [2:0]           drive_offset_current_sel,     // Offset step count.
   output logic      [1:0]           monitor_output_pin_sel,       // Monitor channel.
   output logic      [7:0]           laser_drive_current_code,     // Converter code.
   output logic                      dac_update,          // Converter load pulse.
   output logic      [LBC_CUR_W-1:0] laser_drive_current_q // Drive current, 0.25 mA.
);

   // Register bank state.
   logic [7:0]           range_ff,   nxt_range;      // Photodiode range register.
   logic [7:0]           gainofs_ff, nxt_gainofs;    // Gain and offset register.
   logic [7:0]           monsel_ff,  nxt_monsel;     // Monitor select register.
   logic [7:0]           drive_ff,   nxt_drive;      // Drive code register.
   logic [7:0]           rdata_ff,   nxt_rdata;      // Read data register.
   logic                 rdv_ff,     nxt_rdv;        // Read valid register.
   logic                 upd_ff,     nxt_upd;        // Converter load register.
   logic [LBC_CUR_W-1:0] cur_ff;                     // Registered drive current.
   logic [LBC_CUR_W-1:0] cur_calc;                   // Drive current from next values.

   // Returns true when the offset falls in the converter register range.
   function automatic logic is_dac_addr(input logic [7:0] addr);
      is_dac_addr = (addr == LBC_ADDR_DRIVE) || (addr == LBC_ADDR_DAC_HI);
   endfunction : is_dac_addr

   // Computes the next register contents from the write strobe.
   always_comb
   begin
      nxt_range   = range_ff;
      nxt_gainofs = gainofs_ff;
      nxt_monsel  = monsel_ff;
      nxt_drive   = drive_ff;
      nxt_upd     = 1'b0;
      if (reg_wr_en)
      begin
         // Masking keeps reserved bits at zero whatever is written.
         if (reg_addr == LBC_ADDR_RANGE)
         begin
            nxt_range = reg_wdata & LBC_MASK_RANGE;
         end
         else if (reg_addr == LBC_ADDR_GAINOFS)
         begin
            nxt_gainofs = reg_wdata & LBC_MASK_GAINOFS;
         end
         else if (reg_addr == LBC_ADDR_MONSEL)
         begin
            nxt_monsel = reg_wdata & LBC_MASK_MONSEL;
         end
         else if (reg_addr == LBC_ADDR_DRIVE)
         begin
            nxt_drive = reg_wdata;
         end
         else
         begin
            // Unmapped offsets are ignored.
            nxt_drive = drive_ff;
         end
         // Any write in the converter range loads it at once.
         nxt_upd = is_dac_addr(reg_addr);
      end
   end

   // Computes the read answer; unmapped and reserved bits read zero.
   always_comb
   begin
      nxt_rdv   = reg_rd_en;
      nxt_rdata = rdata_ff;
      if (reg_rd_en)
      begin
         if (reg_addr == LBC_ADDR_RANGE)
         begin
            nxt_rdata = range_ff;
         end
         else if (reg_addr == LBC_ADDR_GAINOFS)
         begin
            nxt_rdata = gainofs_ff;
         end
         else if (reg_addr == LBC_ADDR_MONSEL)
         begin
            nxt_rdata = monsel_ff;
         end
         else if (reg_addr == LBC_ADDR_DRIVE)
         begin
            nxt_rdata = drive_ff;
         end
         else
         begin
            nxt_rdata = 8'h00;
         end
      end
   end

   // Drive current follows the values that the next edge will hold.
   lbc_drive_calc u_drive_calc
   (
      .drive_code (nxt_drive),
      .gain_half  (nxt_gainofs[LBC_GAIN_BIT]),
      .offset_sel (nxt_gainofs[LBC_OFS_LSB +: LBC_OFS_W]),
      .current_q  (cur_calc)
   );

   // Registers all bank state.
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         range_ff   <= LBC_RST_RANGE;
         gainofs_ff <= LBC_RST_GAINOFS;
         monsel_ff  <= LBC_RST_MONSEL;
         drive_ff   <= LBC_RST_DRIVE;
         rdata_ff   <= 8'h00;
         rdv_ff     <= 1'b0;
         upd_ff     <= 1'b0;
         cur_ff     <= '0;
      end
      else
      begin
         range_ff   <= nxt_range;
         gainofs_ff <= nxt_gainofs;
         monsel_ff  <= nxt_monsel;
         drive_ff   <= nxt_drive;
         rdata_ff   <= nxt_rdata;
         rdv_ff     <= nxt_rdv;
         upd_ff     <= nxt_upd;
         cur_ff     <= cur_calc;
      end
   end

   // Outputs come straight from the registers.
   assign reg_rdata                    = rdata_ff;
   assign reg_rd_valid                 = rdv_ff;
   assign monitor_photodiode_low_range = range_ff[LBC_RANGE_BIT];
   assign laser_diode_gain_half        = gainofs_ff[LBC_GAIN_BIT];
   assign drive_offset_current_sel     = gainofs_ff[LBC_OFS_LSB +: LBC_OFS_W];
   assign monitor_output_pin_sel       = monsel_ff[LBC_MON_LSB +: LBC_MON_W];
   assign laser_drive_current_code     = drive_ff;
   assign dac_update                   = upd_ff;
   assign laser_drive_current_q        = cur_ff;

   // A write to either converter offset pulses the load on the next edge.
   chk_dac_load_pulse : assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (reg_wr_en && is_dac_addr(reg_addr)) |=> dac_update
         && laser_drive_current_code == $past(reg_addr == LBC_ADDR_DRIVE ? reg_wdata
                                                : laser_drive_current_code))
      else $error("Converter write did not load at once.");

   // No load pulse appears without a converter write.
   chk_dac_no_spur : assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      dac_update |-> $past(reg_wr_en) && is_dac_addr($past(reg_addr)))
      else $error("Converter load without a write.");

   // Clearing the range bit by write yields the 1:1 range.
   chk_range_clear : assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (reg_wr_en && reg_addr == LBC_ADDR_RANGE)
         |=> monitor_photodiode_low_range == $past(reg_wdata[LBC_RANGE_BIT]))
      else $error("Photodiode range did not follow write.");

   // Full-scale code at unity gain, no offset, gives 127.5 mA.
   chk_drive_unity : assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (!laser_diode_gain_half && drive_offset_current_sel == 3'h0
         && laser_drive_current_code == 8'hFF) |-> laser_drive_current_q == 10'h1FE)
      else $error("Unity gain span is wrong.");

   // Top offset at unity gain and zero code gives 112 mA.
   chk_offset_top : assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (!laser_diode_gain_half && drive_offset_current_sel == 3'h7
         && laser_drive_current_code == 8'h00) |-> laser_drive_current_q == 10'h1C0)
      else $error("Top offset current is wrong.");

   // Half gain at full settings gives 119.75 mA.
   chk_drive_half : assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (laser_diode_gain_half && drive_offset_current_sel == 3'h7
         && laser_drive_current_code == 8'hFF) |-> laser_drive_current_q == 10'h1DF)
      else $error("Half gain span is wrong.");

   // Monitor select holds 3 until written.
   chk_mon_reset : assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(reset_n) |-> monitor_output_pin_sel == 2'h3)
      else $error("Monitor select reset value is wrong.");

   // Reserved bits of the gain and offset register read back as zero.
   chk_reserved_zero : assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $past(reg_rd_en) && $past(reg_addr) == LBC_ADDR_GAINOFS |-> reg_rd_valid
         && reg_rdata[7:4] == 4'h0)
      else $error("Reserved bits read as non-zero.");

endmodule : lbc_regs

//--- tb/lbc_host_model.sv
// Host side model that issues register port strobes for the register bank.
// Assumes the bank takes a strobe on the rising edge and answers one cycle later.
`timescale 1ns/10ps
module lbc_host_model
(
   input  wire logic       sys_clk,      // System clock.
   output logic            reg_wr_en,    // Write strobe.
   output logic            reg_rd_en,    // Read strobe.
   output logic      [7:0] reg_addr,     // Register offset.
   output logic      [7:0] reg_wdata,    // Write data.
   input  wire logic [7:0] reg_rdata,    // Read data.
   input  wire logic       reg_rd_valid, // Read data valid.
   input  wire logic       dac_update    // Converter load pulse.
);
   // Idle values at time zero.
   initial
   begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end
   // One write; the update pulse is sampled in the answer cycle.
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic upd);
      @(posedge sys_clk);
      reg_wr_en <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      // Released lines show the inverse so stale values never pass.
      reg_wr_en <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
      #1 upd = dac_update;
   endtask : wr
   // One read; data and valid are taken in the answer cycle.
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic vld);
      @(posedge sys_clk);
      reg_rd_en <= 1'b1;
      reg_addr  <= a;
      @(posedge sys_clk);
      reg_rd_en <= 1'b0;
      reg_addr  <= ~a;
      #1 d = reg_rdata;
      vld = reg_rd_valid;
   endtask : rd
endmodule : lbc_host_model

//--- tb/laser_bias_config_regs_tb.sv
// Self-checking bench for the laser bias configuration register bank.
// Assumes the host model in lbc_host_model drives every register access.
`timescale 1ns/10ps
module laser_bias_config_regs_tb;
   import lbc_pkg::*;
   logic                 sys_clk = 1'b0;   // 50 MHz clock.
   logic                 reset_n = 1'b0;   // Reset, active low.
   logic                 wr, rd, vld, upd; // Strobes and sampled answers.
   logic [7:0]           addr, wdata, rdata, d;
   logic                 low_range, gain_half, dac_update;
   logic [2:0]           ofs_sel;
   logic [1:0]           mon_sel;
   logic [7:0]           code;
   logic [LBC_CUR_W-1:0] cur_q;
   int                   err_count = 0;
   int                   num_checks = 0;
   always #10 sys_clk = ~sys_clk;
   lbc_host_model host (.sys_clk(sys_clk), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr),
      .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(vld), .dac_update(dac_update));
   lbc_regs uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_wr_en(wr), .reg_rd_en(rd),
      .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(vld),
      .monitor_photodiode_low_range(low_range), .laser_diode_gain_half(gain_half),
      .drive_offset_current_sel(ofs_sel), .monitor_output_pin_sel(mon_sel),
      .laser_drive_current_code(code), .dac_update(dac_update),
      .laser_drive_current_q(cur_q));
   // Compares one value and counts the result.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD t=%0t seen %0h want %0h", $time, seen, exp);
      end
   endtask : check
   // Expected drive current in quarter milliamps, half gain truncates.
   function automatic logic [15:0] exp_q(logic [7:0] c, logic h, logic [2:0] o);
      logic [15:0] s;
      s = 16'(o) * 16'h0040 + 16'(c) * 16'h0002;
      return h ? (s >> 1) : s;
   endfunction : exp_q
   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   // Reset values of outputs, then the first read once reset is released.
   task automatic test_reset();
      check(mon_sel, 16'h0003);
      check(low_range, 16'h0000);
      check(cur_q, 16'h0000);
      check({dac_update, vld, gain_half, ofs_sel, code}, 16'h0000);
      @(posedge sys_clk);
      reset_n <= 1'b1;
      host.rd(LBC_ADDR_MONSEL, d, upd);
      check({upd, d}, 16'h0103);
      $display("test_reset done");
   endtask : test_reset
   // Range bit with reserved bits set around it.
   task automatic test_range();
      host.wr(LBC_ADDR_RANGE, 8'hFE, upd);
      check(low_range, 16'h0000);
      host.wr(LBC_ADDR_RANGE, 8'hFF, upd);
      check(low_range, 16'h0001);
      host.rd(LBC_ADDR_RANGE, d, upd);
      check(d, 16'h0001);
      host.wr(LBC_ADDR_RANGE, 8'h00, upd);
      check(low_range, 16'h0000);
      $display("test_range done");
   endtask : test_range
   // Every gain and offset code at full drive code.
   task automatic test_gain_ofs();
      host.wr(LBC_ADDR_DRIVE, 8'hFF, upd);
      for (int g = 0; g < 2; g++)
         for (int o = 0; o < 8; o++)
         begin
            host.wr(LBC_ADDR_GAINOFS, {4'hA, g[0], o[2:0]}, upd);
            check(upd, 16'h0000);
            check({gain_half, ofs_sel}, 16'(g * 8 + o));
            check(cur_q, exp_q(8'hFF, g[0], o[2:0]));
            host.rd(LBC_ADDR_GAINOFS, d, upd);
            check(d, 16'(g * 8 + o));
         end
      $display("test_gain_ofs done");
   endtask : test_gain_ofs
   // Every monitor channel with reserved bits set.
   task automatic test_monitor();
      for (int m = 0; m < 4; m++)
      begin
         host.wr(LBC_ADDR_MONSEL, {6'h3F, m[1:0]}, upd);
         check(mon_sel, 16'(m));
         host.rd(LBC_ADDR_MONSEL, d, upd);
         check(d, 16'(m));
      end
      $display("test_monitor done");
   endtask : test_monitor
   // Converter writes, the high register and an unmapped offset.
   task automatic test_dac();
      host.wr(LBC_ADDR_GAINOFS, 8'h05, upd);
      host.wr(LBC_ADDR_DRIVE, 8'h80, upd);
      check({upd, code}, 16'h0180);
      check(cur_q, exp_q(8'h80, 1'b0, 3'h5));
      host.wr(LBC_ADDR_DAC_HI, 8'h7E, upd);
      check(upd, 16'h0001);
      host.rd(LBC_ADDR_DAC_HI, d, upd);
      check({upd, d}, 16'h0100);
      host.wr(8'h33, 8'hFF, upd);
      check({upd, code}, 16'h0080);
      host.rd(8'h33, d, upd);
      check({upd, d}, 16'h0100);
      $display("test_dac done");
   endtask : test_dac
   // Top offset at zero code, then a reset in mid-run restores every register.
   task automatic test_mid_reset();
      host.wr(LBC_ADDR_DRIVE, 8'h00, upd);
      host.wr(LBC_ADDR_GAINOFS, 8'h07, upd);
      check(cur_q, exp_q(8'h00, 1'b0, 3'h7));
      host.wr(LBC_ADDR_MONSEL, 8'h01, upd);
      host.wr(LBC_ADDR_RANGE, 8'h01, upd);
      check({mon_sel, low_range}, 16'h0003);
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      #1 check({mon_sel, low_range}, 16'h0006);
      check({gain_half, ofs_sel, code}, 16'h0000);
      check(cur_q, 16'h0000);
      host.rd(LBC_ADDR_MONSEL, d, upd);
      check({upd, d}, 16'h0103);
      $display("test_mid_reset done");
   endtask : test_mid_reset
   // Main sequence.
   initial
   begin
      repeat (10) @(posedge sys_clk);
      #1 test_reset();
      test_range();
      test_gain_ofs();
      test_monitor();
      test_dac();
      test_mid_reset();
      complete_run();
   end
   // Watchdog that ends a hung run as a mismatch.
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      err_count++;
      complete_run();
   end
endmodule : laser_bias_config_regs_tb
